// [bench/pcb_pad_model.sv]
/* Pads outside the bank: own driver, external driver, pulldown.
   Assumes the bench supplies the external drive per pin. */
`timescale 1ns/1ps
`default_nettype none
module pcb_pad_model
  import pcb_pkg::*;
(
  // Controls
  input  wire logic       clock,
  input  wire pcb_pad_t   padCtrl,
  input  wire logic [2:0] extOn,
  input  wire logic [2:0] extLevel,
  // Pad levels
  output logic      [2:0] padIn
);
  logic [2:0] floatNoise_r = 3'b000;
  // A floating pad must not look steady, or a stale level would pass
  always_ff @(posedge clock) floatNoise_r <= ~floatNoise_r;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      padIn[i] = padCtrl.outEnable[i] ? padCtrl.outLevel[i] : extOn[i] ? extLevel[i] :
                 padCtrl.pulldownOn[i] ? 1'b0 : floatNoise_r[i];
    end
  end
endmodule
`default_nettype wire

// [bench/pcb_pin_properties.sv]
/* Port assertions for the pin bank, bound to its top module below.
   Assumes one clock and a synchronous active-high general reset. */
`timescale 1ns/1ps
`default_nettype none
module pcb_pin_checker
  import pcb_pkg::*;
(
  // Watched ports
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       powerOffReset,
  input wire logic       sleepMode,
  input wire logic       inPowerSequence,
  input wire logic       bootDirection,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdData,
  input wire logic [2:0] padIn,
  input wire pcb_pad_t   padCtrl
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ----------
  // Properties
  // ----------
  a_idle_read_zero: assert property (!regRead |=> regRdData == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_read_zero: assert property (regRead && (regAddr < 8'h64 || regAddr > 8'h66) |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_reserved_read_zero: assert property (regRead |=> regRdData[6:5] == 2'b00)
    else $error("reserved bits not zero");
  a_reset_pulldown_on: assert property ($fell(reset) |-> ##[0:2] padCtrl.pulldownOn == 3'b111)
    else $error("pulldown not on after reset");
  a_boot_direction_used: assert property ($fell(reset) |-> ##[0:2] padCtrl.outEnable == {bootDirection, 2'b00})
    else $error("reset direction wrong");
  a_off_reset_pin: assert property (powerOffReset && inPowerSequence |->
    ##[1:2] (padCtrl.outEnable[2] && !padCtrl.pulldownOn[2] && !padCtrl.outLevel[2]))
    else $error("power-off reset did not reach the pin");
  a_write_reaches_pad: assert property (regWrite && regAddr == 8'h64 |-> ##2
    (padCtrl.outEnable[0] == $past(regWrData[2], 2) && padCtrl.pulldownOn[0] == $past(regWrData[3], 2)))
    else $error("write did not reach the pad");
  a_pad_holds_quiet: assert property (!regWrite && !$past(regWrite) && !powerOffReset && !$past(powerOffReset) &&
    !$past(reset) && !$past(reset, 2) && $stable(sleepMode) |=> $stable(padCtrl))
    else $error("pad control changed without cause");
  c_sleep_out: cover property (sleepMode && padCtrl.outEnable[2]);
  c_off_reset: cover property (powerOffReset && inPowerSequence);
  c_unmapped: cover property (regRead && regAddr == 8'h67);
endmodule
bind pcb_pin_bank pcb_pin_checker i_checker (.clock(clock), .reset(reset), .powerOffReset(powerOffReset),
  .sleepMode(sleepMode), .inPowerSequence(inPowerSequence), .bootDirection(bootDirection), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .padIn(padIn),
  .padCtrl(padCtrl));
`default_nettype wire

// [bench/testbench.sv]
/* Directed bench for the pin bank: register tasks and pad model.
   Assumes the package and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pcb_pkg::*;
  logic       clock, reset, powerOffReset, sleepMode, inPowerSequence, bootDirection, regWrite, regRead;
  logic [7:0] regAddr, regWrData, regRdData, v;
  logic [2:0] padIn, extOn, extLevel;
  pcb_pad_t   padCtrl;
  int         n_errors = 0;
  int         checks_done = 0;
  // Short ticks keep debounce runs brief
  pcb_pin_bank #(.SHORT_TICK_CYC(4), .LONG_TICK_CYC(10), .SHORT_SAMPLES(3), .LONG_SAMPLES(3)) i_dut (
    .clock(clock), .reset(reset), .powerOffReset(powerOffReset), .sleepMode(sleepMode),
    .inPowerSequence(inPowerSequence), .bootDirection(bootDirection), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .padIn(padIn), .padCtrl(padCtrl));
  pcb_pad_model i_pad (.clock(clock), .padCtrl(padCtrl), .extOn(extOn), .extLevel(extLevel), .padIn(padIn));
  // -----
  // Tasks
  // -----
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clock);
    regWrite  <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1 v = regRdData;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    #80000;
    n_errors++;
    finish_test();
  end
  initial begin
    {reset, bootDirection, extOn, extLevel} = 8'hff;
    {powerOffReset, sleepMode, inPowerSequence, regWrite, regRead, regAddr, regWrData} = '0;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    rd(8'h66);
    chk(v & 8'hfd, 8'h0c);
    rd(8'h64);
    chk(v, 8'h0a);
    chk(padCtrl, 9'h107);
    wr(8'h64, 8'hff);
    wr(8'h65, 8'he2);
    wr(8'h67, 8'hff);
    rd(8'h64);
    chk(v, 8'h1f);
    rd(8'h65);
    chk(v, 8'h02);
    chk(padCtrl, 9'h14d);
    rd(8'h67);
    chk(v, 8'h00);
    // Debounce, short then long
    @(posedge clock) extLevel <= 3'b101;
    rd(8'h65);
    chk(v, 8'h02);
    idle(30);
    rd(8'h65);
    chk(v, 8'h00);
    wr(8'h65, 8'h10);
    @(posedge clock) extLevel <= 3'b111;
    idle(12);
    rd(8'h65);
    chk(v, 8'h10);
    idle(50);
    rd(8'h65);
    chk(v, 8'h12);
    // Sleep force-low, then with the bit clear
    wr(8'h66, 8'h85);
    @(posedge clock) sleepMode <= 1'b1;
    idle(2);
    chk(padCtrl.outLevel[2], 1'b0);
    wr(8'h66, 8'h05);
    idle(2);
    chk(padCtrl.outLevel[2], 1'b1);
    wr(8'h66, 8'h81);
    idle(2);
    chk(padCtrl.outLevel[2], 1'b1);
    @(posedge clock) sleepMode <= 1'b0;
    // Power-off reset, outside and inside the power-up sequence
    wr(8'h66, 8'h89);
    @(posedge clock) powerOffReset <= 1'b1;
    @(posedge clock) powerOffReset <= 1'b0;
    rd(8'h66);
    chk(v & 8'hfd, 8'h89);
    @(posedge clock);
    inPowerSequence <= 1'b1;
    powerOffReset   <= 1'b1;
    @(posedge clock) powerOffReset <= 1'b0;
    rd(8'h66);
    chk(v & 8'hfd, 8'h84);
    // General reset in mid-run
    @(posedge clock) reset <= 1'b1;
    idle(2);
    @(posedge clock) reset <= 1'b0;
    rd(8'h64);
    chk(v, 8'h0a);
    rd(8'h66);
    chk(v & 8'hfd, 8'h0c);
    // Reset once more with the boot strap low: the sleep-capable pin comes up as an input
    @(posedge clock) begin
      bootDirection <= 1'b0;
      reset         <= 1'b1;
    end
    idle(2);
    @(posedge clock) reset <= 1'b0;
    rd(8'h66);
    chk(v & 8'hfd, 8'h08);
    chk(padCtrl.outEnable, 3'b000);
    finish_test();
  end
endmodule
`default_nettype wire

// [include/pcb_params.svh]
/*
  Register offsets, field positions, reset values and timing counts for
  the pin configuration bank. Assumes a 125 MHz clock.
*/
`ifndef PCB_PARAMS_SVH
`define PCB_PARAMS_SVH

`define PCB_ADDR_PIN4        8'h64
`define PCB_ADDR_PIN5        8'h65
`define PCB_ADDR_PIN6        8'h66

`define PCB_BIT_OUT_VALUE    0
`define PCB_BIT_LEVEL        1
`define PCB_BIT_DIRECTION    2
`define PCB_BIT_PULLDOWN     3
`define PCB_BIT_DEB_SEL      4
`define PCB_BIT_SLEEP_LOW    7

`define PCB_RST_OUT_VALUE    1'b0
`define PCB_RST_LEVEL        1'b1
`define PCB_RST_DIRECTION    1'b0
`define PCB_RST_PULLDOWN     1'b1
`define PCB_RST_DEB_SEL      1'b0
`define PCB_RST_SLEEP_LOW    1'b0

// Times in nanoseconds, clock period in nanoseconds
`define PCB_CLK_PERIOD_NS    8
`define PCB_SHORT_TICK_NS    30500
`define PCB_LONG_TICK_NS     50000000
`define PCB_SHORT_DEB_NS     91500
`define PCB_LONG_DEB_NS      150000000
`define PCB_SHORT_TICK_CYC   ((`PCB_SHORT_TICK_NS + `PCB_CLK_PERIOD_NS - 1) / `PCB_CLK_PERIOD_NS)
`define PCB_LONG_TICK_CYC    ((`PCB_LONG_TICK_NS + `PCB_CLK_PERIOD_NS - 1) / `PCB_CLK_PERIOD_NS)
// Equal samples needed: debounce time over tick, rounded up
`define PCB_SHORT_SAMPLES    ((`PCB_SHORT_DEB_NS + `PCB_SHORT_TICK_NS - 1) / `PCB_SHORT_TICK_NS)
`define PCB_LONG_SAMPLES     ((`PCB_LONG_DEB_NS + `PCB_LONG_TICK_NS - 1) / `PCB_LONG_TICK_NS)

`endif

// [include/pcb_pkg.sv]
/*
  Types for the pin configuration bank. Used by the top module and the bench.
*/
package pcb_pkg;

  typedef struct packed {
    logic       sleepLow;
    logic       debSel;
    logic       pulldownEnable;
    logic       direction;
    logic       outValue;
  } pcb_cfg_t;

  typedef struct packed {
    logic [2:0] outEnable;
    logic [2:0] outLevel;
    logic [2:0] pulldownOn;
  } pcb_pad_t;

endpackage

// [logic/pcb_pin_bank.sv]
/*
  Configuration and status of three general-purpose pins, one byte register
  each at offsets 0x64, 0x65 and 0x66. Pin index 2 is the sleep-capable pin,
  the only one that can take part in the power-up sequence.
  Per pin: output value, direction, pulldown enable and debounce select are
  software fields; the level status bit is the synchronised, debounced pad.
  The pad controls leave as one registered struct, one cycle after a change
  of configuration, so the pad ring never sees decode glitches.

  Assumes:
  - one clock; both resets are synchronous and active high, and the general
    reset wins over the power-off reset when both are high;
  - a plain strobe register port; read data stand in the cycle after the
    read strobe only and read as zero otherwise, and the port never waits;
  - pad inputs synchronous to the clock, still passed through two flops so
    that a slow pad edge cannot split across the debounce logic;
  - a boot strap for the sleep-capable pin's direction that is steady while
    the general reset is high;
  - the power state machine holds the sleep and power-sequence levels
    steady for at least one clock around each change.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pcb_params.svh"


module pcb_pin_bank
  import pcb_pkg::*;
#(
  parameter int SHORT_TICK_CYC = `PCB_SHORT_TICK_CYC,
  parameter int LONG_TICK_CYC  = `PCB_LONG_TICK_CYC,
  parameter int SHORT_SAMPLES  = `PCB_SHORT_SAMPLES,
  parameter int LONG_SAMPLES   = `PCB_LONG_SAMPLES
) (
  // Clock and resets
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       powerOffReset,
  // Power state and boot strap
  input  wire logic       sleepMode,
  input  wire logic       inPowerSequence,
  input  wire logic       bootDirection,
  // Register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdData,
  // Pads
  input  wire logic [2:0] padIn,
  output pcb_pad_t        padCtrl
);

  // ----------------------------------------------------------------
  // Pin indices
  // ----------------------------------------------------------------
  // Decode returns NO_PIN for an address outside the bank
  localparam int         N_PINS    = 3;
  localparam int         SLEEP_PIN = 2;
  localparam logic [1:0] NO_PIN    = 2'd3;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  function automatic logic [1:0] pinIndex(input logic [7:0] addr);
    case (addr)
      `PCB_ADDR_PIN4: pinIndex = 2'd0;
      `PCB_ADDR_PIN5: pinIndex = 2'd1;
      `PCB_ADDR_PIN6: pinIndex = 2'd2;
      default:        pinIndex = NO_PIN;
    endcase
  endfunction

  // Register byte layout, the same on all three pins:
  //   bit 0 output value, bit 1 level status (read only), bit 2 direction,
  //   bit 3 pulldown enable, bit 4 debounce select, bit 7 sleep-low on the
  //   sleep-capable pin only. Other bits read zero and ignore writes.

  // Fields taken from a written byte; the status bit has no storage, so a
  // write to it cannot reach anything
  function automatic pcb_cfg_t cfgFromByte(input logic [7:0] data, input logic hasSleep);
    pcb_cfg_t cfg;
    cfg.outValue       = data[`PCB_BIT_OUT_VALUE];
    cfg.direction      = data[`PCB_BIT_DIRECTION];
    cfg.pulldownEnable = data[`PCB_BIT_PULLDOWN];
    cfg.debSel         = data[`PCB_BIT_DEB_SEL];
    cfg.sleepLow       = hasSleep & data[`PCB_BIT_SLEEP_LOW];
    return cfg;
  endfunction

  // Read byte: stored fields, live status, zero in unused positions
  function automatic logic [7:0] readWord(input pcb_cfg_t cfg, input logic level);
    logic [7:0] word;
    word                     = 8'h00;
    word[`PCB_BIT_OUT_VALUE] = cfg.outValue;
    word[`PCB_BIT_LEVEL]     = level;
    word[`PCB_BIT_DIRECTION] = cfg.direction;
    word[`PCB_BIT_PULLDOWN]  = cfg.pulldownEnable;
    word[`PCB_BIT_DEB_SEL]   = cfg.debSel;
    word[`PCB_BIT_SLEEP_LOW] = cfg.sleepLow;
    return word;
  endfunction

  // Samples a new level must hold before it is taken, by debounce setting
  function automatic logic [3:0] samplesNeeded(input logic longSel);
    samplesNeeded = longSel ? 4'(LONG_SAMPLES) : 4'(SHORT_SAMPLES);
  endfunction

  pcb_cfg_t   cfg_r [3];
  logic [2:0] level_r;
  logic [2:0] syncA_r;
  logic [2:0] syncB_r;
  logic [1:0] wrIdx;
  logic [1:0] rdIdx;

  assign wrIdx = pinIndex(regAddr);
  assign rdIdx = pinIndex(regAddr);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Two ordinary pins: general reset only
  for (genvar p = 0; p < 2; p++) begin : gPlain
    always_ff @(posedge clock) begin
      if (reset) begin
        cfg_r[p].outValue       <= `PCB_RST_OUT_VALUE;
        cfg_r[p].direction      <= `PCB_RST_DIRECTION;
        cfg_r[p].pulldownEnable <= `PCB_RST_PULLDOWN;
        cfg_r[p].debSel         <= `PCB_RST_DEB_SEL;
        cfg_r[p].sleepLow       <= 1'b0;
      end else if (regWrite && wrIdx == 2'(p)) begin
        cfg_r[p] <= cfgFromByte(regWrData, 1'b0);
      end
    end
  end

  // Power-off reset reaches only the sleep-capable pin, and only while that
  // pin belongs to the power-up sequence; outside it the pin keeps its setup
  logic offResetHit;
  assign offResetHit = powerOffReset && inPowerSequence;

  // Sleep-capable pin: general reset wins over power-off reset
  always_ff @(posedge clock) begin
    if (reset) begin
      cfg_r[2].outValue       <= `PCB_RST_OUT_VALUE;
      cfg_r[2].direction      <= bootDirection;
      cfg_r[2].pulldownEnable <= `PCB_RST_PULLDOWN;
      cfg_r[2].debSel         <= `PCB_RST_DEB_SEL;
      cfg_r[2].sleepLow       <= `PCB_RST_SLEEP_LOW;
    end else if (offResetHit) begin
      cfg_r[2].pulldownEnable <= 1'b0;
      cfg_r[2].direction      <= 1'b1;
      cfg_r[2].outValue       <= `PCB_RST_OUT_VALUE;
    end else if (regWrite && wrIdx == 2'd2) begin
      cfg_r[2] <= cfgFromByte(regWrData, 1'b1);
    end
  end

  // ----------------------------------------------------------------
  // Sampling ticks
  // ----------------------------------------------------------------
  // One short and one long tick shared by all pins saves counters. The
  // price: the tick phase is not tied to the pad edge, so a debounce may
  // end up to one tick period before its nominal time.
  // At the default clock the short tick is 3813 cycles, the long one
  // 6250000 cycles; counters are sized from the parameters.
  localparam int SHORT_W = $clog2(SHORT_TICK_CYC + 1);
  localparam int LONG_W  = $clog2(LONG_TICK_CYC + 1);
  logic [SHORT_W-1:0] shortCnt_r;
  logic [LONG_W-1:0]  longCnt_r;
  logic               shortTick_r;
  logic               longTick_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      shortCnt_r  <= '0;
      shortTick_r <= 1'b0;
    end else if (shortCnt_r == SHORT_W'(SHORT_TICK_CYC - 1)) begin
      shortCnt_r  <= '0;
      shortTick_r <= 1'b1;
    end else begin
      shortCnt_r  <= shortCnt_r + SHORT_W'(1);
      shortTick_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      longCnt_r  <= '0;
      longTick_r <= 1'b0;
    end else if (longCnt_r == LONG_W'(LONG_TICK_CYC - 1)) begin
      longCnt_r  <= '0;
      longTick_r <= 1'b1;
    end else begin
      longCnt_r  <= longCnt_r + LONG_W'(1);
      longTick_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Synchroniser and debounce
  // ----------------------------------------------------------------
  // The synchroniser resets high, like the status bit, so that no false
  // change is counted in the first cycles after reset
  always_ff @(posedge clock) begin
    if (reset) begin
      syncA_r <= 3'h7;
      syncB_r <= 3'h7;
    end else begin
      syncA_r <= padIn;
      syncB_r <= syncA_r;
    end
  end

  logic [3:0] stable_r [3];

  for (genvar p = 0; p < N_PINS; p++) begin : gDeb
    logic       tick;
    logic [3:0] need;
    assign tick = cfg_r[p].debSel ? longTick_r : shortTick_r;
    assign need = samplesNeeded(cfg_r[p].debSel);

    // Level accepted only after 'need' consecutive ticks differing from it
    always_ff @(posedge clock) begin
      if (reset) begin
        level_r[p]  <= `PCB_RST_LEVEL;
        stable_r[p] <= 4'h0;
      end else if (syncB_r[p] == level_r[p]) begin
        stable_r[p] <= 4'h0;
      end else if (tick) begin
        if (stable_r[p] + 4'h1 >= need) begin
          level_r[p]  <= syncB_r[p];
          stable_r[p] <= 4'h0;
        end else begin
          stable_r[p] <= stable_r[p] + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pad drive
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      padCtrl <= '0;
    end else begin
      for (int p = 0; p < N_PINS; p++) begin
        padCtrl.outEnable[p]  <= cfg_r[p].direction;
        padCtrl.outLevel[p]   <= cfg_r[p].outValue;
        padCtrl.pulldownOn[p] <= cfg_r[p].pulldownEnable;
      end
      // Force-low acts on an output only; an input keeps its pulldown as set
      if (sleepMode && cfg_r[SLEEP_PIN].sleepLow && cfg_r[SLEEP_PIN].direction) begin
        padCtrl.outLevel[SLEEP_PIN] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      regRdData <= 8'h00;
    end else if (regRead && rdIdx != NO_PIN) begin
      regRdData <= readWord(cfg_r[rdIdx], level_r[rdIdx]);
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule
`default_nettype wire
